// [test/ctrl_model.sv]
// Controller model that drives the selection and run commands.
`timescale 1ns/1ns
module ctrl_model #(parameter int SETTLE = 8) (
    input wire logic clk,
    input wire logic hurry,
    input wire logic [2:0] sel_req,
    input wire logic [3:0] run_req,
    output logic [2:0] sel = 3'h0,
    output logic [3:0] run = 4'h0
);
    int quiet = 0;
    always @(posedge clk) begin
        sel <= sel_req;
        quiet <= (sel_req != sel) ? 0 : quiet + 1;
        // A start waits for a still selection; hurry breaks this on purpose.
        if (run_req == 4'h0 || run != 4'h0 || quiet >= SETTLE || hurry) begin
            run <= run_req;
        end
    end
endmodule

// [test/set_select_assertions.sv]
// Assertions on the ports of the motor parameter set selector.
`timescale 1ns/1ns
module set_select_checker (
    input wire CLOCK, RST, SELECT_SECOND_SET_IN, SELECT_THIRD_SET_IN, SELECT_FOURTH_SET_IN,
    input wire [3:0] RUN_COMMAND_IN,
    input wire SECOND_SET_SWITCH_MODE, FIRST_SET_ACTIVE_OUT, SECOND_SET_ACTIVE_OUT, THIRD_SET_ACTIVE_OUT,
    input wire FOURTH_SET_ACTIVE_OUT, FUNCTIONS_DISABLED_OUT, CHANGE_PENDING_OUT,
    input wire [1:0] GROUP_SET_OUT, SWITCHABLE_SET_OUT
);
    wire [1:0] want = SELECT_SECOND_SET_IN ? 2'h1 : SELECT_THIRD_SET_IN ? 2'h2 : {2{SELECT_FOURTH_SET_IN}};
    wire [3:0] hot = {FOURTH_SET_ACTIVE_OUT, THIRD_SET_ACTIVE_OUT, SECOND_SET_ACTIVE_OUT, FIRST_SET_ACTIVE_OUT};
    wire idle = RUN_COMMAND_IN == 4'h0;
    wire [1:0] grp = GROUP_SET_OUT;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    one_hot_a: assert property ($onehot(hot)) else $error("not one-hot");
    hot_match_a: assert property (hot == 4'h1 << SWITCHABLE_SET_OUT) else $error("bad output");
    idle_take_a: assert property (idle |=> SWITCHABLE_SET_OUT == $past(want)) else $error("bad set");
    motor_hold_a: assert property (!idle && grp != 2'h0 |=> $stable(grp)) else $error("moved");
    pend_set_a: assert property (!idle && grp != 2'h0 && want != grp |=> CHANGE_PENDING_OUT)
        else $error("no pending");
    group_rule_a: assert property (grp == 2'h0 || grp == SWITCHABLE_SET_OUT) else $error("group");
    func_off_a: assert property (FUNCTIONS_DISABLED_OUT == (grp != 2'h0)) else $error("functions");
    mode_pick_a: assert property (idle && SELECT_SECOND_SET_IN |=>
        grp == ($past(SECOND_SET_SWITCH_MODE) ? 2'h0 : 2'h1)) else $error("mode");
endmodule
bind motor_parameter_set_selector set_select_checker set_select_checker_i (.*);

// [test/tb_motor_parameter_set_selector.sv]
// Self-checking testbench for the motor parameter set selector.
`timescale 1ns/1ns
module tb_motor_parameter_set_selector;
    logic CLOCK = 1'b0, RST = 1'b1, hurry = 1'b0;
    logic [2:0] sel_req = 3'h0, mode = 3'h0;
    logic [3:0] run_req = 4'h0;
    wire [2:0] sel;
    wire [3:0] run, hot;
    wire [1:0] grp, swt;
    wire func, pend, viol;
    int n_errors = 0, cmp_count = 0;
    initial forever #2 CLOCK = ~CLOCK;
    ctrl_model ctrl_model_i (.clk(CLOCK), .hurry(hurry), .sel_req(sel_req), .run_req(run_req), .sel(sel), .run(run));
    motor_parameter_set_selector motor_parameter_set_selector_i (.CLOCK(CLOCK), .RST(RST),
        .SELECT_SECOND_SET_IN(sel[0]), .SELECT_THIRD_SET_IN(sel[1]), .SELECT_FOURTH_SET_IN(sel[2]),
        .RUN_COMMAND_IN(run), .SECOND_SET_SWITCH_MODE(mode[0]), .THIRD_SET_SWITCH_MODE(mode[1]),
        .FOURTH_SET_SWITCH_MODE(mode[2]), .FIRST_SET_ACTIVE_OUT(hot[0]), .SECOND_SET_ACTIVE_OUT(hot[1]),
        .THIRD_SET_ACTIVE_OUT(hot[2]), .FOURTH_SET_ACTIVE_OUT(hot[3]), .GROUP_SET_OUT(grp),
        .SWITCHABLE_SET_OUT(swt), .FUNCTIONS_DISABLED_OUT(func), .CHANGE_PENDING_OUT(pend),
        .SETTLE_VIOLATION_OUT(viol));
    task summarize();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [10:0] exp);
        cmp_count++;
        if ({viol, func, pend, grp, swt, hot} !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, {viol, func, pend, grp, swt, hot}, exp);
        end
    endtask
    task put(input logic [2:0] s, input logic [3:0] r, input logic h, input int n);
        @(posedge CLOCK);
        sel_req <= s;
        run_req <= r;
        hurry <= h;
        repeat (n) @(posedge CLOCK);
        #1;
    endtask
    task t_prio();
        logic [1:0] idx;
        for (int i = 0; i < 8; i++) begin
            idx = i[0] ? 2'h1 : i[1] ? 2'h2 : i[2] ? 2'h3 : 2'h0;
            put(i[2:0], 4'h0, 1'b0, 3);
            chk({1'b0, idx != 2'h0, 1'b0, idx, idx, 4'h1 << idx});
        end
        $display("priority test done");
    endtask
    task t_hold();
        put(3'h0, 4'h1, 1'b0, 12);
        put(3'h1, 4'h1, 1'b0, 4);
        chk(11'h501);
        put(3'h1, 4'h0, 1'b0, 3);
        chk(11'h652);
        put(3'h1, 4'h1, 1'b0, 12);
        put(3'h0, 4'h1, 1'b0, 3);
        chk(11'h752);
        $display("hold test done");
    endtask
    task t_param();
        put(3'h0, 4'h0, 1'b0, 3);
        @(posedge CLOCK);
        mode <= 3'h7;
        put(3'h0, 4'h1, 1'b0, 12);
        put(3'h2, 4'h1, 1'b0, 4);
        chk(11'h424);
        put(3'h4, 4'h0, 1'b0, 3);
        chk(11'h438);
        put(3'h1, 4'h1, 1'b1, 3);
        chk(11'h412);
        $display("parameter test done");
    endtask
    initial begin
        repeat (12) @(posedge CLOCK);
        RST <= 1'b0;
        t_prio();
        t_hold();
        t_param();
        summarize();
    end
    initial begin
        #20000;
        n_errors++;
        summarize();
    end
endmodule

// [verilog/motor_parameter_set_selector.v]
// Motor parameter set selector: picks the active set and drives switch outputs.
`timescale 1ns/1ns
`include "set_select_regs.vh"
module motor_parameter_set_selector (
    input wire CLOCK,
    input wire RST,
    input wire SELECT_SECOND_SET_IN,
    input wire SELECT_THIRD_SET_IN,
    input wire SELECT_FOURTH_SET_IN,
    input wire [3:0] RUN_COMMAND_IN,
    input wire SECOND_SET_SWITCH_MODE,
    input wire THIRD_SET_SWITCH_MODE,
    input wire FOURTH_SET_SWITCH_MODE,
    output reg FIRST_SET_ACTIVE_OUT,
    output reg SECOND_SET_ACTIVE_OUT,
    output reg THIRD_SET_ACTIVE_OUT,
    output reg FOURTH_SET_ACTIVE_OUT,
    output reg [1:0] GROUP_SET_OUT,
    output reg [1:0] SWITCHABLE_SET_OUT,
    output reg FUNCTIONS_DISABLED_OUT,
    output reg CHANGE_PENDING_OUT,
    output reg SETTLE_VIOLATION_OUT
);
    // ----------------------------------------------------------------
    // Decode and mode lookup
    // ----------------------------------------------------------------
    wire [1:0] req_set;
    wire running;
    reg req_mode;
    reg cur_mode;
    reg [1:0] active_q;
    reg [1:0] active_d;
    reg [1:0] req_last_q;
    reg [`SETTLE_CNT_W-1:0] settle_q;
    reg run_last_q;
    wire [3:0] onehot;
    wire [2:0] mode_vec;
    set_priority_decode u_decode (
        .sel_second(SELECT_SECOND_SET_IN),
        .sel_third(SELECT_THIRD_SET_IN),
        .sel_fourth(SELECT_FOURTH_SET_IN),
        .set_index(req_set)
    );
    assign running = |RUN_COMMAND_IN;
    assign mode_vec = {FOURTH_SET_SWITCH_MODE, THIRD_SET_SWITCH_MODE, SECOND_SET_SWITCH_MODE};
    // The first set has no mode of its own; it follows the mode of the set left or entered.
    always @* begin
        if (req_set == `SET_FIRST) begin
            req_mode = `MODE_MOTOR;
        end else begin
            req_mode = mode_vec[req_set - 2'h1];
        end
        if (active_q == `SET_FIRST) begin
            cur_mode = `MODE_MOTOR;
        end else begin
            cur_mode = mode_vec[active_q - 2'h1];
        end
    end
    // ----------------------------------------------------------------
    // Change acceptance
    // ----------------------------------------------------------------
    // A change touching any motor-mode set is a real motor swap and must wait for stop.
    always @* begin
        active_d = active_q;
        if (req_set != active_q) begin
            if (req_mode == `MODE_PARAM && cur_mode == `MODE_PARAM) begin
                active_d = req_set;
            end else if (req_set == `SET_FIRST && cur_mode == `MODE_PARAM) begin
                active_d = req_set;
            end else if (req_mode == `MODE_PARAM && active_q == `SET_FIRST) begin
                active_d = req_set;
            end else if (!running) begin
                active_d = req_set;
            end
        end
    end
    // ----------------------------------------------------------------
    // One-hot outputs
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_hot
            assign onehot[i] = (active_d == i);
        end
    endgenerate
    // ----------------------------------------------------------------
    // State and outputs
    // ----------------------------------------------------------------
    always @(posedge CLOCK) begin
        if (RST) begin
            active_q <= `SET_RESET;
            req_last_q <= `SET_RESET;
            settle_q <= {`SETTLE_CNT_W{1'b0}};
            run_last_q <= 1'b0;
            {FOURTH_SET_ACTIVE_OUT, THIRD_SET_ACTIVE_OUT, SECOND_SET_ACTIVE_OUT, FIRST_SET_ACTIVE_OUT}
                <= `ONEHOT_RESET;
            GROUP_SET_OUT <= `SET_RESET;
            SWITCHABLE_SET_OUT <= `SET_RESET;
            FUNCTIONS_DISABLED_OUT <= 1'b0;
            CHANGE_PENDING_OUT <= 1'b0;
            SETTLE_VIOLATION_OUT <= 1'b0;
        end else begin
            active_q <= active_d;
            req_last_q <= req_set;
            run_last_q <= running;
            {FOURTH_SET_ACTIVE_OUT, THIRD_SET_ACTIVE_OUT, SECOND_SET_ACTIVE_OUT, FIRST_SET_ACTIVE_OUT}
                <= onehot;
            SWITCHABLE_SET_OUT <= active_d;
            if (active_d != `SET_FIRST && mode_vec[active_d - 2'h1] == `MODE_PARAM) begin
                GROUP_SET_OUT <= `SET_FIRST;
                FUNCTIONS_DISABLED_OUT <= 1'b0;
            end else begin
                GROUP_SET_OUT <= active_d;
                FUNCTIONS_DISABLED_OUT <= (active_d != `SET_FIRST);
            end
            CHANGE_PENDING_OUT <= (active_d != req_set);
            // Monitor only; the settle time is the controller's duty, so a short one is flagged.
            if (req_set != req_last_q) begin
                settle_q <= {`SETTLE_CNT_W{1'b0}};
            end else if (settle_q != `SETTLE_LIMIT) begin
                settle_q <= settle_q + 1'b1;
            end
            if (running && !run_last_q) begin
                SETTLE_VIOLATION_OUT <= (settle_q != `SETTLE_LIMIT);
            end
        end
    end
endmodule

// [verilog/set_priority_decode.v]
// Priority decoder from the three selection inputs to a set index.
`timescale 1ns/1ns
`include "set_select_regs.vh"
module set_priority_decode (
    input wire sel_second,
    input wire sel_third,
    input wire sel_fourth,
    output reg [1:0] set_index
);
    always @* begin
        if (sel_second) begin
            set_index = `SET_SECOND;
        end else if (sel_third) begin
            set_index = `SET_THIRD;
        end else if (sel_fourth) begin
            set_index = `SET_FOURTH;
        end else begin
            set_index = `SET_FIRST;
        end
    end
endmodule

// [verilog/set_select_regs.vh]
// Constants for the motor parameter set selector.
`ifndef SET_SELECT_REGS_VH
`define SET_SELECT_REGS_VH
// ----------------------------------------------------------------
// Set encodings (index of the active set)
// ----------------------------------------------------------------
`define SET_FIRST 2'h0
`define SET_SECOND 2'h1
`define SET_THIRD 2'h2
`define SET_FOURTH 2'h3
`define SET_RESET 2'h0
// ----------------------------------------------------------------
// Switch mode values
// ----------------------------------------------------------------
`define MODE_MOTOR 1'h0
`define MODE_PARAM 1'h1
// ----------------------------------------------------------------
// One-hot output codes and reset values
// ----------------------------------------------------------------
`define ONEHOT_FIRST 4'h1
`define ONEHOT_RESET 4'h1
// ----------------------------------------------------------------
// Selection settle time before run, and its cycle count at 250 MHz
// ----------------------------------------------------------------
`define SETTLE_TIME_MS 2
`define CLOCK_MHZ 250
`define SETTLE_CYCLES (`SETTLE_TIME_MS * 1000 * `CLOCK_MHZ)
`define SETTLE_CNT_W 20
// The same count sized to the settle counter, so the compare needs no padding.
`define SETTLE_LIMIT 20'h7_A120
`endif
